// ### verilog/bst_pkg.sv
// Package of constants and types for the boundary-scan test port controller
package bst_pkg;
    localparam int IrWidth = 8;
    localparam int BypassWidth = 1;
    localparam int ChainWidth = 52;
    localparam int OpCtlWidth = 3;
    localparam int IdWidth = 32;
    localparam int OeCellLo = 48;
    localparam int OeCellHi = 51;
    localparam int ResetTmsCycles = 5;
    localparam logic [7:0] IrResetValue = 8'h81;
    localparam logic [7:0] IrCaptureValue = 8'h81;
    localparam logic [2:0] OpCtlResetValue = 3'h2;
    // Opcodes with bit 7 as even parity; only low seven bits decode
    localparam logic [6:0] OpExtest = 7'h00;
    localparam logic [6:0] OpIdcode = 7'h01;
    localparam logic [6:0] OpSample = 7'h02;
    localparam logic [6:0] OpBypass = 7'h7F;
    localparam logic [6:0] OpHighz = 7'h06;
    localparam logic [6:0] OpClamp = 7'h07;
    localparam logic [6:0] OpRunt = 7'h09;
    localparam logic [6:0] OpReadOpCtl = 7'h0A;
    localparam logic [6:0] OpWriteOpCtl = 7'h0B;
    typedef enum logic [1:0] {SelBypass, SelChain, SelOpCtl, SelId} bst_sel_e;
    typedef enum logic [3:0] {
        TestLogicReset, RunTestIdle, SelectDrScan, CaptureDr, ShiftDr, Exit1Dr, PauseDr,
        Exit2Dr, UpdateDr, SelectIrScan, CaptureIr, ShiftIr, Exit1Ir, PauseIr, Exit2Ir,
        UpdateIr
    } bst_state_e;
endpackage

// ### verilog/bst_shift_reg.sv
// Serial shift register with parallel capture and reset value
`timescale 1ns/100ps
`default_nettype none
module bst_shift_reg #(
    parameter int Width = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control
    input wire logic clear,
    input wire logic [Width-1:0] clearValue,
    input wire logic capture,
    input wire logic [Width-1:0] captureValue,
    input wire logic shift,
    input wire logic serialIn,
    // Contents
    output logic [Width-1:0] value
);
    if (Width < 1) begin : gWidthCheck
        $error("bst_shift_reg needs Width of at least 1");
    end

    logic [Width-1:0] value_q;

    always_ff @(posedge clk) begin
        if (!reset_n || clear) begin
            value_q <= clearValue;
        end else if (capture) begin
            value_q <= captureValue;
        end else if (shift) begin
            // One expression serves every width, one-bit included
            value_q <= Width'({serialIn, value_q} >> 1);
        end
    end

    assign value = value_q;
endmodule
`default_nettype wire

// ### verilog/bst_tap_controller.sv
// Boundary-scan test access port controller with its test registers
`timescale 1ns/100ps
`default_nettype none
module bst_tap_controller
    import bst_pkg::*;
#(
    parameter logic [31:0] IdCode = 32'h0000_0001 // Arbitrary identification value
) (
    // System clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Test access port pins, pulled up outside when left open
    input wire logic testClock,
    input wire logic testModeSelect,
    input wire logic testDataIn,
    output logic testDataOut,
    output logic testDataOutEn,
    // Pin states observed by the chain
    input wire logic [ChainWidth-1:0] pinSample,
    input wire logic [1:0] port_output_enable_n,
    // Test state seen by the device core
    output logic testMode,
    output logic [ChainWidth-1:0] pinCellOut,
    output logic [OpCtlWidth-1:0] opCtl,
    output logic testOpRun,
    output logic [IrWidth-1:0] instruction
);
    // Pin synchronisers; first stage read only by the second
    logic [2:0] syncA_q;
    logic [2:0] syncB_q;
    logic tckPrev_q;
    logic tckRise;
    logic tckFall;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            // Clock bit low like the idle pin, so no false edge follows reset
            syncA_q <= 3'h3;
            syncB_q <= 3'h3;
            tckPrev_q <= 1'b0;
        end else begin
            syncA_q <= {testClock, testModeSelect, testDataIn};
            syncB_q <= syncA_q;
            tckPrev_q <= syncB_q[2];
        end
    end

    assign tckRise = syncB_q[2] && !tckPrev_q;
    assign tckFall = !syncB_q[2] && tckPrev_q;

    wire tms = syncB_q[1];
    wire tdi = syncB_q[0];

    bst_state_e state_q;
    bst_state_e state_d;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            TestLogicReset: state_d = tms ? TestLogicReset : RunTestIdle;
            RunTestIdle: state_d = tms ? SelectDrScan : RunTestIdle;
            SelectDrScan: state_d = tms ? SelectIrScan : CaptureDr;
            CaptureDr: state_d = tms ? Exit1Dr : ShiftDr;
            ShiftDr: state_d = tms ? Exit1Dr : ShiftDr;
            Exit1Dr: state_d = tms ? UpdateDr : PauseDr;
            PauseDr: state_d = tms ? Exit2Dr : PauseDr;
            Exit2Dr: state_d = tms ? UpdateDr : ShiftDr;
            UpdateDr: state_d = tms ? SelectDrScan : RunTestIdle;
            SelectIrScan: state_d = tms ? TestLogicReset : CaptureIr;
            CaptureIr: state_d = tms ? Exit1Ir : ShiftIr;
            ShiftIr: state_d = tms ? Exit1Ir : ShiftIr;
            Exit1Ir: state_d = tms ? UpdateIr : PauseIr;
            PauseIr: state_d = tms ? Exit2Ir : PauseIr;
            Exit2Ir: state_d = tms ? UpdateIr : ShiftIr;
            UpdateIr: state_d = tms ? SelectDrScan : RunTestIdle;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= TestLogicReset;
        end else if (tckRise) begin
            state_q <= state_d;
        end
    end

    wire inReset = (state_q == TestLogicReset);
    wire advance = tckRise;

    // Instruction decode, parity checked
    function automatic bst_sel_e decodeSel(input logic [IrWidth-1:0] op);
        bst_sel_e sel;
        sel = SelBypass;
        if (^op == 1'b0) begin
            unique case (op[6:0])
                OpExtest, OpSample, OpRunt, OpClamp, OpHighz: sel = SelChain;
                OpIdcode: sel = SelId;
                OpReadOpCtl, OpWriteOpCtl: sel = SelOpCtl;
                default: sel = SelBypass;
            endcase
        end
        return sel;
    endfunction

    function automatic logic opTestMode(input logic [IrWidth-1:0] op);
        logic tm;
        tm = 1'b0;
        if (^op == 1'b0) begin
            tm = (op[6:0] == OpExtest) || (op[6:0] == OpRunt) || (op[6:0] == OpClamp)
                || (op[6:0] == OpHighz);
        end
        return tm;
    endfunction

    logic [IrWidth-1:0] instruction_q;
    bst_sel_e sel;
    assign sel = decodeSel(instruction_q);

    // Phase of the cycle: rising edge steps shift registers
    wire capDr = advance && (state_q == CaptureDr);
    wire shDr = advance && (state_q == ShiftDr);
    wire capIr = advance && (state_q == CaptureIr);
    wire shIr = advance && (state_q == ShiftIr);

    logic [IrWidth-1:0] irShift;
    logic [0:0] bypassShift;
    logic [ChainWidth-1:0] chainShift;
    logic [OpCtlWidth-1:0] opCtlShift;
    logic [IdWidth-1:0] idShift;
    logic [OeCellHi-OeCellLo:0] oeCell_q;
    logic [OeCellLo-1:0] dataCell_q;
    logic [OpCtlWidth-1:0] opCtl_q;

    // Enable cells 51 and 50 gated by the observed port enables; 48 and 49 captured as sampled
    logic [ChainWidth-1:0] chainCapture;
    always_comb begin
        chainCapture = pinSample;
        chainCapture[OeCellHi-1:OeCellLo] = {3{1'b0}} | pinSample[OeCellHi-1:OeCellLo];
        chainCapture[OeCellHi] = !port_output_enable_n[1] && pinSample[OeCellHi];
        chainCapture[OeCellHi-1] = !port_output_enable_n[0] && pinSample[OeCellHi-1];
    end

    bst_shift_reg #(.Width(IrWidth)) irReg (
        .clk(clk),
        .reset_n(reset_n),
        .clear(inReset),
        .clearValue(IrResetValue),
        .capture(capIr),
        .captureValue(IrCaptureValue),
        .shift(shIr),
        .serialIn(tdi),
        .value(irShift)
    );

    bst_shift_reg #(.Width(BypassWidth)) bypassReg (
        .clk(clk),
        .reset_n(reset_n),
        .clear(1'b0),
        .clearValue(1'b0),
        .capture(capDr && sel == SelBypass),
        .captureValue(1'b0),
        .shift(shDr && sel == SelBypass),
        .serialIn(tdi),
        .value(bypassShift)
    );

    bst_shift_reg #(.Width(ChainWidth)) chainReg (
        .clk(clk),
        .reset_n(reset_n),
        .clear(1'b0),
        .clearValue({ChainWidth{1'b0}}),
        .capture(capDr && sel == SelChain),
        .captureValue(chainCapture),
        .shift(shDr && sel == SelChain),
        .serialIn(tdi),
        .value(chainShift)
    );

    bst_shift_reg #(.Width(OpCtlWidth)) opCtlReg (
        .clk(clk),
        .reset_n(reset_n),
        .clear(1'b0),
        .clearValue(OpCtlResetValue),
        .capture(capDr && sel == SelOpCtl),
        .captureValue(opCtl_q),
        .shift(shDr && sel == SelOpCtl),
        .serialIn(tdi),
        .value(opCtlShift)
    );

    bst_shift_reg #(.Width(IdWidth)) idReg (
        .clk(clk),
        .reset_n(reset_n),
        .clear(1'b0),
        .clearValue(IdCode),
        .capture(capDr && sel == SelId),
        .captureValue(IdCode),
        .shift(shDr && sel == SelId),
        .serialIn(tdi),
        .value(idShift)
    );

    // Update and output work on the falling edge
    wire fallUpdDr = tckFall && (state_q == UpdateDr);
    wire fallUpdIr = tckFall && (state_q == UpdateIr);

    always_ff @(posedge clk) begin
        if (!reset_n || inReset) begin
            instruction_q <= IrResetValue;
        end else if (fallUpdIr) begin
            instruction_q <= irShift;
        end
    end

    // Only enable cells clear in TestLogicReset; data cells clear only from reset_n
    always_ff @(posedge clk) begin
        if (!reset_n || inReset) begin
            oeCell_q <= 4'h0;
        end else if (fallUpdDr && sel == SelChain) begin
            oeCell_q <= chainShift[OeCellHi:OeCellLo];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dataCell_q <= {OeCellLo{1'b0}};
        end else if (fallUpdDr && sel == SelChain) begin
            dataCell_q <= chainShift[OeCellLo-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n || inReset) begin
            opCtl_q <= OpCtlResetValue;
        end else if (fallUpdDr && sel == SelOpCtl
                     && instruction_q[6:0] == OpWriteOpCtl) begin
            opCtl_q <= opCtlShift;
        end
    end

    // Serial output mux and enable, registered at the falling edge
    logic serialBit;
    always_comb begin
        serialBit = bypassShift[0];
        if (state_q == ShiftIr) begin
            serialBit = irShift[0];
        end else begin
            unique case (sel)
                SelBypass: serialBit = bypassShift[0];
                SelChain: serialBit = chainShift[0];
                SelOpCtl: serialBit = opCtlShift[0];
                SelId: serialBit = idShift[0];
            endcase
        end
    end

    wire inShift = (state_q == ShiftDr) || (state_q == ShiftIr);
    logic tdo_q;
    logic tdoEn_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tdo_q <= 1'b0;
            tdoEn_q <= 1'b0;
        end else if (tckFall) begin
            tdo_q <= inShift ? serialBit : 1'b0;
            tdoEn_q <= inShift;
        end
    end

    // Test state driven to the core
    logic testMode_q;
    logic testOpRun_q;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            testMode_q <= 1'b0;
            testOpRun_q <= 1'b0;
        end else begin
            testMode_q <= !inReset && opTestMode(instruction_q);
            // Runs only in idle with OpRunt loaded; reset loads OpIdcode, so reset exit alone starts nothing
            testOpRun_q <= (state_q == RunTestIdle) && (^instruction_q == 1'b0)
                && (instruction_q[6:0] == OpRunt);
        end
    end

    assign testDataOut = tdo_q;
    assign testDataOutEn = tdoEn_q;
    assign testMode = testMode_q;
    assign testOpRun = testOpRun_q;
    assign pinCellOut = {oeCell_q, dataCell_q};
    assign opCtl = opCtl_q;
    assign instruction = instruction_q;

    // Assertions
    logic [2:0] tmsHighCnt_q;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tmsHighCnt_q <= 3'h0;
        end else if (tckRise) begin
            tmsHighCnt_q <= !tms ? 3'h0 : (tmsHighCnt_q == 3'h7 ? 3'h7 : tmsHighCnt_q + 3'h1);
        end
    end

    reset_five_a: assert property (@(posedge clk) disable iff (!reset_n)
        tmsHighCnt_q >= 3'h5 |-> state_q == TestLogicReset)
        else $error("five high mode cycles did not reach reset");
    select_leave_a: assert property (@(posedge clk) disable iff (!reset_n)
        tckRise && (state_q == SelectDrScan || state_q == SelectIrScan)
        |=> state_q != $past(state_q))
        else $error("scan select state held");
    ir_reset_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == TestLogicReset |=> instruction_q == IrResetValue)
        else $error("instruction not reset");
    oe_cells_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == TestLogicReset |=> oeCell_q == 4'h0)
        else $error("enable cells not cleared");
    opctl_reset_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == TestLogicReset |=> opCtl_q == OpCtlResetValue)
        else $error("operation control not reset");
    tdo_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        tckFall && !inShift |=> !testDataOutEn)
        else $error("serial output driven outside shift");
    tdo_on_a: assert property (@(posedge clk) disable iff (!reset_n)
        tckFall && state_q == ShiftDr |=> testDataOutEn && testDataOut == $past(serialBit))
        else $error("serial output not enabled in shift");
    tdo_falling_a: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(testDataOutEn) |-> $past(tckFall))
        else $error("serial enable moved off falling edge");
    capture_ir_a: assert property (@(posedge clk) disable iff (!reset_n)
        capIr |=> irShift == IrCaptureValue)
        else $error("status pattern not captured");
    op_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
        testOpRun |-> $past(state_q) == RunTestIdle)
        else $error("test operation outside idle");

    shift_dr_c: cover property (@(posedge clk) disable iff (!reset_n) shDr && sel == SelId);
    update_ir_c: cover property (@(posedge clk) disable iff (!reset_n) fallUpdIr);
    run_op_c: cover property (@(posedge clk) disable iff (!reset_n) testOpRun);
endmodule
`default_nettype wire

// ### bench/bst_tester.sv
// Behavioural boundary-scan tester on the far side of the test port
`timescale 1ns/100ps
`default_nettype none
module bst_tester (
    // System clock
    input wire logic clk,
    // Test port
    output logic testClock,
    output logic testModeSelect,
    output logic testDataIn,
    input wire logic testDataOut,
    input wire logic testDataOutEn
);
    // Clock idles low outside frames; open lines read high
    initial begin
        testClock = 1'b0;
        testModeSelect = 1'b1;
        testDataIn = 1'b1;
    end
    // One 160 ns cycle, 5 clk low and 3 high; output sampled just before the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo, output logic en);
        @(posedge clk);
        testModeSelect <= tms;
        testDataIn <= tdi;
        repeat (3) @(posedge clk);
        @(negedge clk);
        tdo = testDataOut;
        en = testDataOutEn;
        @(posedge clk);
        testClock <= 1'b1;
        repeat (3) @(posedge clk);
        testClock <= 1'b0;
        // Hold ends with the fall, so released lines float high
        testModeSelect <= 1'b1;
        testDataIn <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ### bench/bst_tap_controller_tb.sv
// Self-checking bench for the boundary-scan test port controller
`timescale 1ns/100ps
`default_nettype none
module bst_tap_controller_tb;
    import bst_pkg::*;
    localparam logic [31:0] TbIdCode = 32'h5A3C_0F96; // Arbitrary value
    logic clk;
    logic reset_n;
    logic testClock;
    logic testModeSelect;
    logic testDataIn;
    logic testDataOut;
    logic testDataOutEn;
    logic [ChainWidth-1:0] pinSample;
    logic [1:0] port_output_enable_n;
    logic testMode;
    logic [ChainWidth-1:0] pinCellOut;
    logic [OpCtlWidth-1:0] opCtl;
    logic testOpRun;
    logic [IrWidth-1:0] instruction;
    int errors;
    int check_count;
    int cycles;
    bst_state_e st;
    logic [7:0] irSh;
    logic [7:0] expIr;
    logic [2:0] expOpCtl;
    logic [63:0] rnd;
    logic [51:0] expChain;
    logic [7:0] byp [3];

    bst_tap_controller #(.IdCode(TbIdCode)) i_bst_tap_controller (
        .clk(clk), .reset_n(reset_n), .testClock(testClock),
        .testModeSelect(testModeSelect), .testDataIn(testDataIn),
        .testDataOut(testDataOut), .testDataOutEn(testDataOutEn), .pinSample(pinSample),
        .port_output_enable_n(port_output_enable_n), .testMode(testMode),
        .pinCellOut(pinCellOut), .opCtl(opCtl), .testOpRun(testOpRun),
        .instruction(instruction)
    );
    bst_tester i_bst_tester (
        .clk(clk), .testClock(testClock), .testModeSelect(testModeSelect),
        .testDataIn(testDataIn), .testDataOut(testDataOut), .testDataOutEn(testDataOutEn)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic final_report();
        $display("Checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Generous ceiling; the run needs about 4100 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            $display("MISMATCH timeout expected done seen hang");
            final_report();
        end
    end

    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] seen);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic bst_state_e tap_next(bst_state_e s, logic t);
        case (s)
            TestLogicReset: return t ? TestLogicReset : RunTestIdle;
            RunTestIdle: return t ? SelectDrScan : RunTestIdle;
            SelectDrScan: return t ? SelectIrScan : CaptureDr;
            CaptureDr, ShiftDr: return t ? Exit1Dr : ShiftDr;
            Exit1Dr: return t ? UpdateDr : PauseDr;
            PauseDr: return t ? Exit2Dr : PauseDr;
            Exit2Dr: return t ? UpdateDr : ShiftDr;
            SelectIrScan: return t ? TestLogicReset : CaptureIr;
            CaptureIr, ShiftIr: return t ? Exit1Ir : ShiftIr;
            Exit1Ir: return t ? UpdateIr : PauseIr;
            PauseIr: return t ? Exit2Ir : PauseIr;
            Exit2Ir: return t ? UpdateIr : ShiftIr;
            default: return t ? SelectDrScan : RunTestIdle;
        endcase
    endfunction

    function automatic logic [7:0] par(input logic [6:0] op);
        return {^op, op};
    endfunction

    task automatic model_reset();
        st = TestLogicReset;
        irSh = IrResetValue;
        expIr = IrResetValue;
        expOpCtl = OpCtlResetValue;
    endtask

    // One test cycle; outputs sampled with the tester, before the rising edge
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        logic en;
        logic [7:0] ins;
        logic [2:0] oc;
        logic run;
        logic [4:0] idle;
        logic tm;
        logic tmExp;
        fork
            i_bst_tester.step(tms, tdi, tdo, en);
            begin
                repeat (4) @(posedge clk);
                @(negedge clk);
                ins = instruction;
                oc = opCtl;
                run = testOpRun;
                idle = {pinCellOut[51:48], testMode};
                tm = testMode;
            end
        join
        check("outEnable", 64'(st inside {ShiftDr, ShiftIr}), 64'(en));
        tmExp = st != TestLogicReset && ^expIr == 1'b0
            && expIr[6:0] inside {OpExtest, OpRunt, OpClamp, OpHighz};
        check("testMode", 64'(tmExp), 64'(tm));
        check("instruction", 64'(expIr), 64'(ins));
        check("opCtl", 64'(expOpCtl), 64'(oc));
        check("testOpRun", 64'(st == RunTestIdle && expIr == par(OpRunt)), 64'(run));
        if (st == TestLogicReset) check("resetCells", 64'h0, 64'(idle));
        if (st == CaptureIr) irSh = IrCaptureValue;
        else if (st == ShiftIr) irSh = {tdi, irSh[7:1]};
        st = tap_next(st, tms);
        if (st == UpdateIr) expIr = irSh;
        if (st == TestLogicReset) model_reset();
    endtask

    // Scan from idle back to idle, with an optional pause in mid-shift
    task automatic scan(input logic isIr, input int len, input logic [63:0] cap,
                        input logic [63:0] din, input int n, input int pauseAt, input logic wr);
        logic b;
        logic [63:0] exp;
        logic [63:0] dout;
        exp = '0;
        dout = '0;
        step(1'b1, 1'b1, b);
        if (isIr) step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
        step(1'b0, 1'b1, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1 || i == pauseAt, din[i], b);
            dout[i] = b;
            exp[i] = i < len ? cap[i] : din[i - len];
            if (i == pauseAt) begin
                step(1'b0, 1'b1, b);
                step(1'b0, 1'b1, b);
                step(1'b1, 1'b1, b);
                step(1'b0, 1'b1, b);
            end
        end
        step(1'b1, 1'b1, b);
        if (wr) expOpCtl = din[2:0];
        step(1'b0, 1'b1, b);
        if (!wr) check(isIr ? "irScanOut" : "drScanOut", exp, dout);
    endtask

    task automatic load_ir(input logic [7:0] op);
        scan(1'b1, 8, 64'(IrCaptureValue), 64'(op), 8, -1, 1'b0);
    endtask

    initial begin
        logic b;
        reset_n = 1'b0;
        pinSample = '0;
        port_output_enable_n = 2'b11;
        errors = 0;
        check_count = 0;
        cycles = 0;
        model_reset();
        void'($urandom(32'h89637317));
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk);
        step(1'b0, 1'b1, b);
        rnd = {$urandom, $urandom};
        scan(1'b0, 32, 64'(TbIdCode), rnd, 40, 12, 1'b0);
        // Bypass, bad parity and unsupported opcodes all give a one-bit path
        byp[0] = par(OpBypass);
        byp[1] = {~^OpIdcode, OpIdcode};
        byp[2] = par(7'h03);
        foreach (byp[k]) begin
            load_ir(byp[k]);
            rnd = {$urandom, $urandom};
            scan(1'b0, 1, 64'h0, rnd, 60, -1, 1'b0);
        end
        load_ir(par(OpWriteOpCtl));
        rnd = 64'($urandom_range(7, 3));
        scan(1'b0, 3, 64'h0, rnd, 3, -1, 1'b1);
        load_ir(par(OpReadOpCtl));
        scan(1'b0, 3, 64'(expOpCtl), 64'h0, 6, -1, 1'b0);
        load_ir(par(OpRunt));
        repeat (3) step(1'b0, 1'b1, b);
        @(posedge clk);
        pinSample <= 52'({$urandom, $urandom});
        port_output_enable_n <= 2'($urandom);
        load_ir(par(OpSample));
        expChain = pinSample;
        expChain[51] = expChain[51] & ~port_output_enable_n[1];
        expChain[50] = expChain[50] & ~port_output_enable_n[0];
        rnd = {$urandom, $urandom};
        scan(1'b0, 52, 64'(expChain), rnd, 60, 20, 1'b0);
        check("pinCellOut", 64'(rnd[59:8]), 64'(pinCellOut));
        // Mode select held high from inside a data shift
        load_ir(par(OpBypass));
        step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
        step(1'b0, 1'b1, b);
        repeat (5) step(1'b1, 1'b1, b);
        step(1'b1, 1'b1, b);
        // Reset pin in mid-run, with bypass loaded
        step(1'b0, 1'b1, b);
        load_ir(par(OpBypass));
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        model_reset();
        repeat (5) @(posedge clk);
        step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
        rnd = {$urandom, $urandom};
        scan(1'b0, 32, 64'(TbIdCode), rnd, 32, -1, 1'b0);
        final_report();
    end
endmodule
`default_nettype wire
